// [design/fpm_pkg.sv]
// constants, register map and commands of the program flash block
// assumes one 100 MHz clock and an 8-bit register port
//
// Contract
// - eight 1 kB sectors of 64-byte pages
// - page buffer programs 1 to 64 bytes
// - separate sector erase and page erase
// - chip erase clears whole user array
// - any single byte erasable and programmable
// - code reads of secured sectors refused
// - 32-bit CRC over sector or all
// - program or erase done within 2 ms
// - boot status zero starts at 0000H
// - nonzero status boots at vector:00H
// - boot vector ships as 1FH
// - forced serial mode boots via vector
// - eight registers: control, data, two address, four crc result
// - eight security bytes, one per sector
// - config byte latched once after reset
// - top 512 bytes hold serial loader
package fpm_pkg;

  // ***************
  // geometry
  // ***************
  localparam int ADDR_W       = 13;
  localparam int FLASH_BYTES  = 8192;
  localparam int SECTOR_BYTES = 1024;
  localparam int PAGE_BYTES   = 64;
  localparam int SECTORS      = 8;
  localparam logic [12:0] LOADER_BASE = 13'h1E00;

  // ***************
  // register map
  // ***************
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_DATA    = 4'h1;
  localparam logic [3:0] REG_ADDR_LO = 4'h2;
  localparam logic [3:0] REG_ADDR_HI = 4'h3;
  localparam logic [3:0] REG_CRC0    = 4'h4;
  localparam logic [3:0] REG_CRC3    = 4'h7;
  localparam int CTRL_BUSY_BIT = 7;
  localparam int CTRL_ERR_BIT  = 6;

  // ***************
  // commands
  // ***************
  typedef enum logic [3:0] {
    CMD_NONE      = 4'h0,
    CMD_LOAD      = 4'h1,
    CMD_PROG_PAGE = 4'h2,
    CMD_ERASE_BYTE = 4'h3,
    CMD_ERASE_PAGE = 4'h4,
    CMD_ERASE_SECT = 4'h5,
    CMD_ERASE_CHIP = 4'h6,
    CMD_CRC_SECT  = 4'h7,
    CMD_CRC_ALL   = 4'h8,
    CMD_PROG_BYTE = 4'h9,
    CMD_READ      = 4'hA,
    CMD_SPC_WRITE = 4'hB
  } fpm_cmd_t;

  // ***************
  // special elements
  // ***************
  localparam logic [3:0] SPC_SEC0  = 4'h0;
  localparam logic [3:0] SPC_CFG   = 4'h8;
  localparam logic [3:0] SPC_BVEC  = 4'h9;
  localparam logic [3:0] SPC_BSTAT = 4'hA;
  localparam int         SPC_N     = 11;
  localparam logic [7:0] BOOT_VECTOR_DEF = 8'h1F;
  localparam logic [7:0] BOOT_STATUS_DEF = 8'h01;
  localparam logic [7:0] CFG_DEF         = 8'h00;
  localparam logic [7:0] SEC_DEF         = 8'h00;
  localparam logic [7:0] ERASED          = 8'hFF;
  localparam logic [15:0] APP_START      = 16'h0000;
  localparam logic [7:0]  BOOT_LOW       = 8'h00;
  localparam logic [15:0] BOOT_ROM_ENTRY = 16'hFF00;

  // ***************
  // timing
  // ***************
  localparam int OP_TIME_US = 2000;
  localparam int CLK_MHZ    = 100;
  localparam int OP_CYCLES_DEF = OP_TIME_US * CLK_MHZ;

  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;

endpackage

// [design/fpm_crc_step.sv]
// one-byte step of the reflected 32-bit CRC
// assumes caller holds the running value
`timescale 1ns/1ns
module fpm_crc_step (
  input  wire logic [31:0] crc_in,
  input  wire logic [7:0]  data_in,
  output logic      [31:0] crc_out
);

  always_comb begin
    logic [31:0] c;
    c = crc_in ^ {24'h000000, data_in};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ fpm_pkg::CRC_POLY) : (c >> 1);
    end
    crc_out = c;
  end

endmodule

// [design/fpm_flash_ctrl.sv]
// program flash array, page buffer, operation engine, code read gate and boot select
// assumes register strobes and code reads synchronous to clk
`timescale 1ns/1ns
module fpm_flash_ctrl #(
  parameter int OP_CYCLES = fpm_pkg::OP_CYCLES_DEF
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [7:0]  reg_rdata,
  input  wire logic        code_rd,
  input  wire logic [12:0] code_addr,
  output logic      [7:0]  code_data,
  output logic             code_denied,
  input  wire logic        isp_force,
  output logic             boot_valid,
  output logic      [15:0] boot_addr,
  output logic      [7:0]  user_cfg,
  output logic             busy
);

  // the walk must end before the count runs out, and the count fits 18 bits
  if (OP_CYCLES <= fpm_pkg::FLASH_BYTES + 1 || OP_CYCLES > 2**18) begin : g_bad_cycles
    $error("OP_CYCLES outside the range the sequencer serves");
  end

  // factory vector must land inside the loader region
  localparam logic [15:0] BOOT_DEF_ADDR = {fpm_pkg::BOOT_VECTOR_DEF, fpm_pkg::BOOT_LOW};
  if (BOOT_DEF_ADDR < {3'b000, fpm_pkg::LOADER_BASE}) begin : g_bad_vector
    $error("default boot vector outside loader region");
  end

  // ***************
  // storage
  // ***************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WORK = 2'b01,
    ST_WAIT = 2'b10
  } fpm_state_t;

  logic [7:0]  mem_q [fpm_pkg::FLASH_BYTES];
  // nonvolatile special bytes start at their shipped values
  logic [7:0]  spc_q [fpm_pkg::SPC_N] = '{
    fpm_pkg::SEC_DEF,
    fpm_pkg::SEC_DEF,
    fpm_pkg::SEC_DEF,
    fpm_pkg::SEC_DEF,
    fpm_pkg::SEC_DEF,
    fpm_pkg::SEC_DEF,
    fpm_pkg::SEC_DEF,
    fpm_pkg::SEC_DEF,
    fpm_pkg::CFG_DEF,
    fpm_pkg::BOOT_VECTOR_DEF,
    fpm_pkg::BOOT_STATUS_DEF
  };
  logic [7:0]  pbuf_q [fpm_pkg::PAGE_BYTES];
  logic [63:0] pmask_q;

  fpm_state_t        state_q;
  fpm_pkg::fpm_cmd_t cmd_q;
  logic [7:0]        data_q;
  logic [7:0]        addr_lo_q;
  logic [4:0]        addr_hi_q;
  logic [12:0]       walk_q;
  logic [12:0]       last_q;
  logic [17:0]       cnt_q;
  logic [31:0]       crc_q;
  logic [31:0]       crc_nx;
  logic              err_q;
  logic              boot_pend_q;

  logic [12:0] flash_addr;
  logic        ctrl_wr;
  logic        cmd_ok;
  logic        start;
  logic        working;
  logic [7:0]  walk_byte;
  fpm_pkg::fpm_cmd_t new_cmd;

  assign flash_addr = {addr_hi_q, addr_lo_q};
  assign new_cmd    = fpm_pkg::fpm_cmd_t'(reg_wdata[3:0]);
  assign ctrl_wr    = reg_we && reg_addr == fpm_pkg::REG_CTRL && state_q == ST_IDLE;
  assign cmd_ok     = reg_wdata[3:0] >= 4'h1 && reg_wdata[3:0] <= 4'hB;
  assign start      = ctrl_wr && cmd_ok && new_cmd != fpm_pkg::CMD_LOAD
                      && new_cmd != fpm_pkg::CMD_READ;
  assign working    = state_q == ST_WORK;
  assign walk_byte  = mem_q[walk_q];

  fpm_crc_step u_crc (
    .crc_in  (crc_q),
    .data_in (walk_byte),
    .crc_out (crc_nx)
  );

  // ***************
  // operation sequencer
  // ***************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cmd_q   <= fpm_pkg::CMD_NONE;
      walk_q  <= 13'h0000;
      last_q  <= 13'h0000;
      cnt_q   <= 18'h00000;
      busy    <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_WORK;
            cmd_q   <= new_cmd;
            busy    <= 1'b1;
            cnt_q   <= 18'(OP_CYCLES - 1);
            unique case (new_cmd)
              fpm_pkg::CMD_PROG_PAGE, fpm_pkg::CMD_ERASE_PAGE: begin
                walk_q <= {flash_addr[12:6], 6'h00};
                last_q <= {flash_addr[12:6], 6'h3F};
              end
              fpm_pkg::CMD_ERASE_SECT, fpm_pkg::CMD_CRC_SECT: begin
                walk_q <= {flash_addr[12:10], 10'h000};
                last_q <= {flash_addr[12:10], 10'h3FF};
              end
              fpm_pkg::CMD_ERASE_CHIP, fpm_pkg::CMD_CRC_ALL: begin
                walk_q <= 13'h0000;
                last_q <= 13'h1FFF;
              end
              default: begin
                walk_q <= flash_addr;
                last_q <= flash_addr;
              end
            endcase
          end
        end
        ST_WORK: begin
          cnt_q <= cnt_q - 18'h00001;
          if (walk_q == last_q) begin
            state_q <= ST_WAIT;
          end else begin
            walk_q <= walk_q + 13'h0001;
          end
        end
        ST_WAIT: begin
          cnt_q <= cnt_q - 18'h00001;
          if (cnt_q == 18'h00000) begin
            state_q <= ST_IDLE;
            busy    <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy    <= 1'b0;
        end
      endcase
    end
  end

  // ***************
  // array writes
  // ***************
  always_ff @(posedge clk) begin
    if (working) begin
      unique case (cmd_q)
        fpm_pkg::CMD_PROG_PAGE: begin
          if (pmask_q[walk_q[5:0]]) begin
            mem_q[walk_q] <= pbuf_q[walk_q[5:0]];
          end
        end
        fpm_pkg::CMD_PROG_BYTE: begin
          mem_q[walk_q] <= data_q;
        end
        fpm_pkg::CMD_ERASE_BYTE, fpm_pkg::CMD_ERASE_PAGE,
        fpm_pkg::CMD_ERASE_SECT, fpm_pkg::CMD_ERASE_CHIP: begin
          mem_q[walk_q] <= fpm_pkg::ERASED;
        end
        default: begin
        end
      endcase
    end
  end

  // special elements are rewritten only by their own command
  always_ff @(posedge clk) begin
    if (working && cmd_q == fpm_pkg::CMD_SPC_WRITE && addr_lo_q < 8'(fpm_pkg::SPC_N)) begin
      spc_q[addr_lo_q[3:0]] <= data_q;
    end
  end

  // ***************
  // page buffer
  // ***************
  always_ff @(posedge clk) begin
    if (ctrl_wr && new_cmd == fpm_pkg::CMD_LOAD) begin
      pbuf_q[addr_lo_q[5:0]] <= data_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pmask_q <= 64'h0000000000000000;
    end else if (ctrl_wr && new_cmd == fpm_pkg::CMD_LOAD) begin
      pmask_q[addr_lo_q[5:0]] <= 1'b1;
    end else if (working && cmd_q == fpm_pkg::CMD_PROG_PAGE && walk_q == last_q) begin
      pmask_q <= 64'h0000000000000000;
    end
  end

  // ***************
  // crc engine
  // ***************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_q <= fpm_pkg::CRC_INIT;
    end else if (start && (new_cmd == fpm_pkg::CMD_CRC_SECT || new_cmd == fpm_pkg::CMD_CRC_ALL)) begin
      crc_q <= fpm_pkg::CRC_INIT;
    end else if (working && (cmd_q == fpm_pkg::CMD_CRC_SECT || cmd_q == fpm_pkg::CMD_CRC_ALL)) begin
      crc_q <= crc_nx;
    end
  end

  // ***************
  // register port
  // ***************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_q    <= 8'h00;
      addr_lo_q <= 8'h00;
      addr_hi_q <= 5'h00;
      err_q     <= 1'b0;
    end else begin
      if (reg_we && state_q == ST_IDLE) begin
        unique case (reg_addr)
          fpm_pkg::REG_DATA:    data_q    <= reg_wdata;
          fpm_pkg::REG_ADDR_LO: addr_lo_q <= reg_wdata;
          fpm_pkg::REG_ADDR_HI: addr_hi_q <= reg_wdata[4:0];
          fpm_pkg::REG_CTRL:    err_q     <= !cmd_ok;
          default: begin
          end
        endcase
      end
      if (ctrl_wr && new_cmd == fpm_pkg::CMD_READ) begin
        data_q <= mem_q[flash_addr];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_re) begin
      unique case (reg_addr)
        fpm_pkg::REG_CTRL:    reg_rdata <= {busy, err_q, 2'b00, cmd_q};
        fpm_pkg::REG_DATA:    reg_rdata <= data_q;
        fpm_pkg::REG_ADDR_LO: reg_rdata <= addr_lo_q;
        fpm_pkg::REG_ADDR_HI: reg_rdata <= {3'b000, addr_hi_q};
        4'h4:                 reg_rdata <= ~crc_q[7:0];
        4'h5:                 reg_rdata <= ~crc_q[15:8];
        4'h6:                 reg_rdata <= ~crc_q[23:16];
        fpm_pkg::REG_CRC3:    reg_rdata <= ~crc_q[31:24];
        default:              reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ***************
  // code read gate
  // ***************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_data   <= 8'h00;
      code_denied <= 1'b0;
    end else if (code_rd) begin
      if (spc_q[code_addr[12:10]] != fpm_pkg::SEC_DEF) begin
        code_data   <= 8'h00;
        code_denied <= 1'b1;
      end else begin
        code_data   <= mem_q[code_addr];
        code_denied <= 1'b0;
      end
    end
  end

  // ***************
  // boot select and config latch
  // ***************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      boot_pend_q <= 1'b1;
      boot_valid  <= 1'b0;
      boot_addr   <= fpm_pkg::APP_START;
      user_cfg    <= 8'h00;
    end else if (boot_pend_q) begin
      boot_pend_q <= 1'b0;
      boot_valid  <= 1'b1;
      user_cfg    <= spc_q[fpm_pkg::SPC_CFG];
      if (isp_force || spc_q[fpm_pkg::SPC_BSTAT] != 8'h00) begin
        boot_addr <= {spc_q[fpm_pkg::SPC_BVEC], fpm_pkg::BOOT_LOW};
      end else begin
        boot_addr <= fpm_pkg::APP_START;
      end
    end
  end

endmodule

// [verif/fpm_props.sv]
// port checker for the program flash block
// assumes binding into fpm_flash_ctrl, one clock domain
`timescale 1ns/1ns
module fpm_props #(
  parameter int OP_CYCLES = fpm_pkg::OP_CYCLES_DEF
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_we,
  input wire logic        reg_re,
  input wire logic [7:0]  reg_rdata,
  input wire logic        code_rd,
  input wire logic [12:0] code_addr,
  input wire logic [7:0]  code_data,
  input wire logic        code_denied,
  input wire logic        isp_force,
  input wire logic        boot_valid,
  input wire logic [15:0] boot_addr,
  input wire logic [7:0]  user_cfg,
  input wire logic        busy
);
  // ***********
  // checks
  // ***********
  logic [31:0] cnt_q;
  logic        go;
  assign go = reg_we && reg_addr == fpm_pkg::REG_CTRL && !busy;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= busy ? cnt_q + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_busy_start: assert property (go && reg_wdata[3:0] inside {[4'h2:4'h9], 4'hB} |=> busy)
    else $error("timed command did not raise busy");
  a_busy_len: assert property ($fell(busy) |-> cnt_q == OP_CYCLES)
    else $error("busy length wrong");
  a_busy_cause: assert property ($rose(busy) |-> $past(go))
    else $error("busy rose without an accepted command");
  a_cmd_instant: assert property (go &&
    reg_wdata[3:0] inside {4'h0, 4'h1, 4'hA, [4'hC:4'hF]} |=> !busy)
    else $error("untimed command raised busy");
  a_rdata_idle: assert property (!$past(reg_re) |-> reg_rdata == 8'h00)
    else $error("read data outside read answer");
  a_denied_zero: assert property (code_denied |-> code_data == 8'h00)
    else $error("refused code read leaked data");
  a_code_hold: assert property (!$past(code_rd) |->
    $stable(code_data) && $stable(code_denied))
    else $error("code output changed without fetch");
  a_boot_hold: assert property ($past(boot_valid) |-> boot_valid && $stable(boot_addr)
    && $stable(user_cfg))
    else $error("boot state changed after latch");
  a_boot_low: assert property (boot_valid |-> boot_addr[7:0] == fpm_pkg::BOOT_LOW)
    else $error("boot address low byte not zero");
endmodule

bind fpm_flash_ctrl fpm_props #(.OP_CYCLES(OP_CYCLES)) u_fpm_props (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .reg_re(reg_re), .reg_rdata(reg_rdata), .code_rd(code_rd), .code_addr(code_addr),
  .code_data(code_data), .code_denied(code_denied), .isp_force(isp_force),
  .boot_valid(boot_valid), .boot_addr(boot_addr), .user_cfg(user_cfg), .busy(busy)
);

// [verif/fpm_fw.sv]
// firmware-side model: register cycles and code fetches
// assumes one clock shared with the flash block
`timescale 1ns/1ns
module fpm_fw (
  input  wire logic        clk,
  input  wire logic [7:0]  reg_rdata,
  input  wire logic [7:0]  code_data,
  input  wire logic        code_denied,
  output logic      [3:0]  reg_addr,
  output logic      [7:0]  reg_wdata,
  output logic             reg_we,
  output logic             reg_re,
  output logic             code_rd,
  output logic      [12:0] code_addr
);
  // ***********
  // bus tasks
  // ***********
  // firmware enters the boot rom here
  localparam logic [15:0] ENTRY = fpm_pkg::BOOT_ROM_ENTRY;
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
    code_rd = 1'b0;
    code_addr = 13'h0000;
  end
  // released data lines show the inverse
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    reg_wdata <= ~v;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic cr(input logic [12:0] a, output logic [7:0] v, output logic n);
    @(posedge clk);
    code_addr <= a;
    code_rd <= 1'b1;
    @(posedge clk);
    code_rd <= 1'b0;
    code_addr <= ~a;
    #1;
    v = code_data;
    n = code_denied;
  endtask
  task automatic spc(input logic [3:0] idx, input logic [7:0] v);
    wr(fpm_pkg::REG_ADDR_LO, {4'h0, idx});
    wr(fpm_pkg::REG_DATA, v);
    wr(fpm_pkg::REG_CTRL, {4'h0, fpm_pkg::CMD_SPC_WRITE});
  endtask
endmodule

// [verif/testbench.sv]
// self-checking bench for the program flash block
// assumes fpm_fw drives the register and code ports
`timescale 1ns/1ns
module testbench;
  // ***********
  // bench
  // ***********
  localparam int OPC = 8200;
  logic        clk, rst, isp_force, reg_we, reg_re, code_rd, code_denied, boot_valid, busy;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, code_data, user_cfg, d, r;
  logic [12:0] code_addr;
  logic [15:0] boot_addr;
  logic [31:0] c;
  int          fail_count, comparisons, seed;
  int          mem [8192];
  fpm_flash_ctrl #(.OP_CYCLES(OPC)) u_fpm_flash_ctrl (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .code_rd(code_rd), .code_addr(code_addr),
    .code_data(code_data), .code_denied(code_denied), .isp_force(isp_force),
    .boot_valid(boot_valid), .boot_addr(boot_addr), .user_cfg(user_cfg), .busy(busy)
  );
  fpm_fw u_fpm_fw (
    .clk(clk), .reg_rdata(reg_rdata), .code_data(code_data), .code_denied(code_denied),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .code_rd(code_rd), .code_addr(code_addr)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("counts: %0d compares, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic idle();
    #1;
    while (busy === 1'b1) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic op(input logic [3:0] cmd);
    u_fpm_fw.wr(fpm_pkg::REG_CTRL, {4'h0, cmd});
    idle();
  endtask
  task automatic seta(input int a);
    u_fpm_fw.wr(fpm_pkg::REG_ADDR_LO, 8'(a));
    u_fpm_fw.wr(fpm_pkg::REG_ADDR_HI, 8'(a >> 8));
  endtask
  task automatic cchk(input int a, input logic den);
    logic [7:0] v;
    logic       n;
    u_fpm_fw.cr(13'(a), v, n);
    chk(v, den ? 32'h0 : mem[a]);
    chk(n, den);
  endtask
  task automatic crange(input int lo, input int hi);
    for (int a = lo; a <= hi; a++) cchk(a, 1'b0);
  endtask
  task automatic rdcrc();
    for (int i = 0; i < 4; i++) begin
      u_fpm_fw.rd(4'(fpm_pkg::REG_CRC0 + i), r);
      c[8*i +: 8] = r;
    end
  endtask
  function automatic logic [31:0] crc_of(input int lo, input int n);
    logic [31:0] x;
    x = fpm_pkg::CRC_INIT;
    for (int i = lo; i < lo + n; i++) begin
      x = x ^ 32'(mem[i] & 32'hFF);
      for (int b = 0; b < 8; b++) x = x[0] ? (x >> 1) ^ fpm_pkg::CRC_POLY : x >> 1;
    end
    return ~x;
  endfunction
  task automatic rst_pulse(input logic f);
    @(posedge clk);
    rst <= 1'b1;
    isp_force <= f;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // ***********
  // tests
  // ***********
  initial begin
    repeat (110000) @(posedge clk);
    fail_count++;
    $display("watchdog expired");
    finish_test();
  end
  initial begin
    seed = 32'h30B9;
    rst = 1'b1;
    isp_force = 1'b0;
    fail_count = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(boot_addr, 16'h1F00);
    chk(boot_valid, 1'b1);
    chk(user_cfg, fpm_pkg::CFG_DEF);
    u_fpm_fw.rd(4'hC, d);
    chk(d, 8'h00);
    u_fpm_fw.wr(fpm_pkg::REG_CTRL, 8'h0F);
    u_fpm_fw.rd(fpm_pkg::REG_CTRL, d);
    chk(d[7:6], 2'b01);
    $display("test regs done");
    u_fpm_fw.wr(fpm_pkg::REG_DATA, 8'h00);
    u_fpm_fw.wr(fpm_pkg::REG_CTRL, {4'h0, fpm_pkg::CMD_ERASE_CHIP});
    u_fpm_fw.wr(fpm_pkg::REG_DATA, 8'h5A);
    u_fpm_fw.rd(fpm_pkg::REG_CTRL, d);
    chk(d[7], 1'b1);
    idle();
    u_fpm_fw.rd(fpm_pkg::REG_DATA, d);
    chk(d, 8'h00);
    foreach (mem[i]) mem[i] = 32'hFF;
    cchk(0, 1'b0);
    cchk(13'h1FFF, 1'b0);
    for (int k = 0; k < 3; k++) begin
      d = 8'($random(seed));
      mem[13'h0440 + (k == 2 ? 63 : k)] = d;
      u_fpm_fw.wr(fpm_pkg::REG_DATA, d);
      seta(13'h0440 + (k == 2 ? 63 : k));
      u_fpm_fw.wr(fpm_pkg::REG_CTRL, 8'h01);
    end
    seta(13'h0440);
    op(fpm_pkg::CMD_PROG_PAGE);
    crange(13'h0440, 13'h047F);
    d = 8'($random(seed));
    mem[5] = d;
    u_fpm_fw.wr(fpm_pkg::REG_DATA, d);
    seta(5);
    op(fpm_pkg::CMD_PROG_BYTE);
    u_fpm_fw.wr(fpm_pkg::REG_CTRL, {4'h0, fpm_pkg::CMD_READ});
    u_fpm_fw.rd(fpm_pkg::REG_DATA, r);
    chk(r, d);
    seta(13'h0440);
    op(fpm_pkg::CMD_ERASE_BYTE);
    mem[13'h0440] = 32'hFF;
    crange(13'h043F, 13'h0441);
    $display("test program done");
    seta(13'h0400);
    op(fpm_pkg::CMD_CRC_SECT);
    rdcrc();
    chk(c, crc_of(1024, 1024));
    op(fpm_pkg::CMD_CRC_ALL);
    rdcrc();
    chk(c, crc_of(0, 8192));
    $display("test crc done");
    seta(13'h047F);
    op(fpm_pkg::CMD_ERASE_PAGE);
    for (int a = 13'h0440; a < 13'h0480; a++) mem[a] = 32'hFF;
    crange(13'h0440, 13'h047F);
    cchk(5, 1'b0);
    seta(13'h03FF);
    op(fpm_pkg::CMD_ERASE_SECT);
    mem[5] = 32'hFF;
    crange(0, 13'h03FF);
    $display("test erase done");
    u_fpm_fw.spc(fpm_pkg::SPC_SEC0 + 4'h1, 8'h01);
    idle();
    cchk(13'h0400, 1'b1);
    cchk(13'h03FF, 1'b0);
    cchk(13'h0800, 1'b0);
    u_fpm_fw.spc(fpm_pkg::SPC_CFG, 8'hA5);
    idle();
    chk(user_cfg, fpm_pkg::CFG_DEF);
    u_fpm_fw.spc(fpm_pkg::SPC_BSTAT, 8'h00);
    idle();
    rst_pulse(1'b0);
    chk(boot_addr, fpm_pkg::APP_START);
    chk(boot_valid, 1'b1);
    chk(user_cfg, 8'hA5);
    rst_pulse(1'b1);
    chk(boot_addr, 16'h1F00);
    d = 8'($random(seed));
    u_fpm_fw.spc(fpm_pkg::SPC_BVEC, d);
    idle();
    rst_pulse(1'b1);
    chk(boot_addr, {d, 8'h00});
    chk(boot_valid, 1'b1);
    $display("test boot done");
    finish_test();
  end
endmodule
